// [verilog/baau_pkg.sv]
/*
 * constants and types for the binary accumulator arithmetic unit.
 * assumes a single core clock; shared by the unit and its bcd adder.
 */
package baau_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int ACC_W = 32;
	localparam int HALF_W = 16;
	localparam int DIGITS = 8;
	localparam int STACK_DEPTH = 8;
	localparam int RUN_W = 6;
	localparam int BIT_ADDR_W = 11;
	localparam int BIT_SPACE = 2048;

	// ****************************************
	// values and field positions
	// ****************************************
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] BCD_ADJUST = 4'h6;
	localparam logic [5:0] RUN_MIN = 6'h01;
	localparam logic [5:0] RUN_MAX = 6'h20;
	localparam int SIGN32 = 31;
	localparam int SIGN16 = 15;

	// ****************************************
	// opcodes
	// ****************************************
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_ADD_WORD = 4'b0001,
		OP_ADD_DOUBLE = 4'b0010,
		OP_SUB_WORD = 4'b0011,
		OP_SUB_DOUBLE = 4'b0100,
		OP_MULTIPLY = 4'b0101,
		OP_DIVIDE = 4'b0110,
		OP_INCREMENT = 4'b0111,
		OP_DECREMENT = 4'b1000,
		OP_BCD_ADD = 4'b1001
	} baau_op_type;

	typedef struct packed {
		logic zero;
		logic carry16;
		logic carry32;
		logic borrow16;
		logic borrow32;
		logic negative;
		logic signError;
		logic operandSize;
		logic invalidBcd;
	} baau_flags_type;

endpackage : baau_pkg

// [verilog/baau_bcd_if.sv]
/*
 * carrier between the arithmetic unit and its bcd adder.
 * assumes both ends share the core clock domain.
 */
`timescale 1ns/1ps
interface baau_bcd_if;
	logic [31:0] augend;
	logic [31:0] addend;
	logic [31:0] sum;
	logic carry16;
	logic carry32;
	logic badDigit;
	modport master (output augend, output addend, input sum,
		input carry16, input carry32, input badDigit);
	modport adder (input augend, input addend, output sum,
		output carry16, output carry32, output badDigit);
endinterface : baau_bcd_if

// [verilog/baau_bcd_adder.sv]
/*
 * combinational eight-digit bcd adder with digit validity check.
 * assumes the caller registers the results.
 */
`timescale 1ns/1ps
module baau_bcd_adder
	import baau_pkg::*;
(
	baau_bcd_if.adder bus
);

	logic [DIGITS:0] carryChain;
	logic [DIGITS-1:0] badA;
	logic [DIGITS-1:0] badB;

	assign carryChain[0] = 1'b0;

	// ****************************************
	// per digit add with decimal adjust
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < DIGITS; g++) begin : gDigit
			logic [3:0] da;
			logic [3:0] db;
			logic [4:0] raw;
			logic over;
			logic [4:0] adj;
			assign da = bus.augend[g*4 +: 4];
			assign db = bus.addend[g*4 +: 4];
			assign badA[g] = da > BCD_MAX_DIGIT;
			assign badB[g] = db > BCD_MAX_DIGIT;
			assign raw = {1'b0, da} + {1'b0, db} + {4'h0, carryChain[g]};
			assign over = raw > {1'b0, BCD_MAX_DIGIT};
			assign adj = over ? raw + {1'b0, BCD_ADJUST} : raw;
			assign bus.sum[g*4 +: 4] = adj[3:0];
			assign carryChain[g+1] = over;
		end
	endgenerate

	// carry out of digit 3 is the 16-bit decimal carry
	assign bus.carry16 = carryChain[DIGITS/2];
	assign bus.carry32 = carryChain[DIGITS];
	assign bus.badDigit = |badA | |badB;

endmodule : baau_bcd_adder

// [verilog/baau_arith_unit.sv]
/*
 * binary accumulator arithmetic unit: add, subtract, multiply, divide,
 * increment, decrement and the bcd formatted add, with status flags and
 * an accumulator stack. assumes the sequencer presents one instruction
 * per start pulse with operands already fetched from data memory.
 */
//
// Overview of operation
// RULE_01 - word add: low accumulator half plus 16-bit operand, unsigned
// RULE_02 - double add: full accumulator plus 32-bit operand, sum kept
// RULE_03 - carry16 on carry out of bit 15, carry32 out of bit 31
// RULE_04 - binary adds set sign error on signed overflow
// RULE_05 - word subtract: accumulator minus 16-bit operand into accumulator
// RULE_06 - double subtract: full accumulator minus 32-bit operand
// RULE_07 - borrow16 for word subtract, borrow32 for double subtract
// RULE_08 - every instruction here sets zero flag on zero result
// RULE_09 - add, subtract, multiply, divide set negative flag from result
// RULE_10 - multiply: low accumulator half times 16-bit operand, full product
// RULE_11 - divide: quotient to accumulator, remainder pushed to stack top
// RULE_12 - divide raises operand-size error when divisor unusable
// RULE_13 - increment adds one to memory word, zero flag from result
// RULE_14 - decrement subtracts one from memory word, zero flag from result
// RULE_15 - bcd add of 1..32 discrete bits from given address to accumulator
// RULE_16 - bcd add flags invalid digits in either operand
// RULE_17 - flags overwritten by next instruction that updates them
// RULE_18 - flags not updated by an instruction keep their value
`timescale 1ns/1ps
module baau_arith_unit
	import baau_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire baau_op_type opcode,
	input wire logic useConst,
	input wire logic [15:0] memWord,
	input wire logic [15:0] memWordHigh,
	input wire logic [31:0] constValue,
	input wire logic [BIT_SPACE-1:0] discreteBits,
	input wire logic [BIT_ADDR_W-1:0] bitAddr,
	input wire logic [RUN_W-1:0] bitCount,
	input wire logic accLoad,
	input wire logic [31:0] accLoadValue,
	output logic [31:0] accumulator,
	output logic [31:0] stackTop,
	output logic [15:0] memWriteData,
	output logic memWriteEn,
	output logic done,
	output logic zeroResultFlag,
	output logic carry16Flag,
	output logic carry32Flag,
	output logic borrow16Flag,
	output logic borrow32Flag,
	output logic negativeFlag,
	output logic signErrorFlag,
	output logic operandSizeFlag,
	output logic invalidBcdFlag
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [31:0] acc;
		logic [STACK_DEPTH-1:0][31:0] stack;
		logic [15:0] memOut;
		logic memWe;
		logic done;
		baau_flags_type flags;
	} baau_state_type;

	baau_state_type state_q;
	baau_state_type state_d;

	baau_bcd_if bcdBus();

	baau_bcd_adder uAdder (
		.bus(bcdBus.adder)
	);

	// ****************************************
	// operand selection
	// ****************************************
	logic [15:0] op16;
	logic [31:0] op32;
	logic [31:0] fieldBits;
	logic [31:0] fieldMask;

	assign op16 = useConst ? constValue[15:0] : memWord;
	assign op32 = useConst ? constValue : {memWordHigh, memWord};
	// gather the discrete run, bits past the run length masked to zero
	assign fieldMask = (bitCount >= RUN_MAX) ? '1 :
		((32'h0000_0001 << bitCount) - 32'h0000_0001);

	genvar b;
	generate
		for (b = 0; b < ACC_W; b++) begin : gField
			logic [BIT_ADDR_W:0] idx;
			assign idx = {1'b0, bitAddr} + (BIT_ADDR_W+1)'(b);
			// addresses past the end of the bit space read as zero
			assign fieldBits[b] = fieldMask[b] &
				(idx < (BIT_ADDR_W+1)'(BIT_SPACE)) &
				discreteBits[idx[BIT_ADDR_W-1:0]];
		end
	endgenerate

	assign bcdBus.augend = state_q.acc;
	assign bcdBus.addend = fieldBits;

	// ****************************************
	// arithmetic
	// ****************************************
	logic [32:0] addSum;
	logic [31:0] addA;
	logic [31:0] binary_add_word;
	logic [16:0] lowSum;
	logic [32:0] subDiff;
	logic [31:0] binary_sub_word;
	logic [16:0] lowDiff;
	logic [31:0] product;
	logic [31:0] quotient;
	logic [31:0] remainder;
	logic [15:0] incValue;
	logic [15:0] decValue;

	always_comb begin
		addA = state_q.acc;
		binary_add_word = op32;
		if (opcode == OP_ADD_WORD) begin
			addA = {ZERO16, state_q.acc[15:0]}; // [RULE_01]
			binary_add_word = {ZERO16, op16};
		end
	end

	assign addSum = {1'b0, addA} + {1'b0, binary_add_word}; // [RULE_02]
	assign lowSum = {1'b0, addA[15:0]} + {1'b0, binary_add_word[15:0]};
	assign binary_sub_word = (opcode == OP_SUB_WORD) ? {ZERO16, op16} : op32;
	assign subDiff = {1'b0, state_q.acc} - {1'b0, binary_sub_word}; // [RULE_05] [RULE_06]
	assign lowDiff = {1'b0, state_q.acc[15:0]} - {1'b0, binary_sub_word[15:0]};
	assign product = {ZERO16, state_q.acc[15:0]} * {ZERO16, op16}; // [RULE_10]
	// a zero divisor is refused: quotient keeps the accumulator, remainder is zero
	assign quotient = (op16 == ZERO16) ? state_q.acc :
		state_q.acc / {ZERO16, op16};
	assign remainder = (op16 == ZERO16) ? ACC_RESET :
		state_q.acc % {ZERO16, op16};
	assign incValue = memWord + ONE16; // [RULE_13]
	assign decValue = memWord - ONE16; // [RULE_14]

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] res;
		res = ACC_RESET;
		state_d = state_q;
		state_d.done = 1'b0;
		state_d.memWe = 1'b0;
		if (accLoad) begin
			state_d.acc = accLoadValue;
		end
		// each branch writes only the flags its instruction owns
		if (start) begin // [RULE_17] [RULE_18]
			state_d.done = 1'b1;
			case (opcode)
				OP_ADD_WORD, OP_ADD_DOUBLE: begin
					res = addSum[31:0];
					state_d.acc = res;
					state_d.flags.carry16 = lowSum[16]; // [RULE_03]
					state_d.flags.carry32 = addSum[32]; // [RULE_03]
					state_d.flags.signError = (addA[SIGN32] == binary_add_word[SIGN32]) &
						(res[SIGN32] != addA[SIGN32]); // [RULE_04]
					state_d.flags.zero = res == ACC_RESET; // [RULE_08]
					state_d.flags.negative = res[SIGN32]; // [RULE_09]
				end
				OP_SUB_WORD, OP_SUB_DOUBLE: begin
					res = subDiff[31:0];
					state_d.acc = res;
					if (opcode == OP_SUB_WORD) begin
						state_d.flags.borrow16 = lowDiff[16]; // [RULE_07]
					end else begin
						state_d.flags.borrow32 = subDiff[32]; // [RULE_07]
					end
					state_d.flags.zero = res == ACC_RESET; // [RULE_08]
					state_d.flags.negative = res[SIGN32]; // [RULE_09]
				end
				OP_MULTIPLY: begin
					res = product;
					state_d.acc = res;
					state_d.flags.zero = res == ACC_RESET; // [RULE_08]
					state_d.flags.negative = res[SIGN32]; // [RULE_09]
				end
				OP_DIVIDE: begin
					// zero divisor: accumulator and stack kept, error raised
					state_d.flags.operandSize = op16 == ZERO16; // [RULE_12]
					res = quotient;
					if (op16 != ZERO16) begin
						state_d.acc = res; // [RULE_11]
						state_d.stack = {state_q.stack[STACK_DEPTH-2:0],
							remainder}; // [RULE_11]
					end
					state_d.flags.zero = res == ACC_RESET; // [RULE_08]
					state_d.flags.negative = res[SIGN32]; // [RULE_09]
				end
				OP_INCREMENT: begin
					state_d.memOut = incValue; // [RULE_13]
					state_d.memWe = 1'b1;
					state_d.flags.zero = incValue == ZERO16; // [RULE_13]
				end
				OP_DECREMENT: begin
					state_d.memOut = decValue; // [RULE_14]
					state_d.memWe = 1'b1;
					state_d.flags.zero = decValue == ZERO16; // [RULE_14]
				end
				OP_BCD_ADD: begin
					// a run length outside 1..32 leaves accumulator and flags as they were
					if (bitCount >= RUN_MIN && bitCount <= RUN_MAX) begin
						res = bcdBus.sum;
						state_d.acc = res; // [RULE_15]
						state_d.flags.invalidBcd = bcdBus.badDigit; // [RULE_16]
						state_d.flags.carry16 = bcdBus.carry16;
						state_d.flags.carry32 = bcdBus.carry32;
						state_d.flags.zero = res == ACC_RESET; // [RULE_08]
						state_d.flags.negative = res[SIGN32];
					end
				end
				default: begin
					state_d.done = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign accumulator = state_q.acc;
	assign stackTop = state_q.stack[0];
	assign memWriteData = state_q.memOut;
	assign memWriteEn = state_q.memWe;
	assign done = state_q.done;
	assign zeroResultFlag = state_q.flags.zero;
	assign carry16Flag = state_q.flags.carry16;
	assign carry32Flag = state_q.flags.carry32;
	assign borrow16Flag = state_q.flags.borrow16;
	assign borrow32Flag = state_q.flags.borrow32;
	assign negativeFlag = state_q.flags.negative;
	assign signErrorFlag = state_q.flags.signError;
	assign operandSizeFlag = state_q.flags.operandSize;
	assign invalidBcdFlag = state_q.flags.invalidBcd;

endmodule : baau_arith_unit

// [verif/baau_arith_unit_properties.sv]
/* port checker for the arithmetic unit, bound into it.
 * assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module baau_arith_unit_properties
	import baau_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire baau_op_type opcode,
	input wire logic useConst,
	input wire logic accLoad,
	input wire logic [15:0] memWord,
	input wire logic [15:0] memWordHigh,
	input wire logic [31:0] constValue,
	input wire logic [31:0] accumulator,
	input wire logic [31:0] stackTop,
	input wire logic [15:0] memWriteData,
	input wire logic memWriteEn,
	input wire logic zeroResultFlag,
	input wire logic carry16Flag,
	input wire logic carry32Flag,
	input wire logic borrow16Flag,
	input wire logic negativeFlag,
	input wire logic signErrorFlag,
	input wire logic operandSizeFlag,
	input wire logic invalidBcdFlag
);
	logic [15:0] op16;
	logic [31:0] op32;
	logic [32:0] sum33;
	logic go;
	assign op16 = useConst ? constValue[15:0] : memWord;
	assign op32 = useConst ? constValue : {memWordHigh, memWord};
	assign sum33 = {1'b0, accumulator} + {1'b0, op32};
	// a load in the same cycle is left out: its precedence is a choice
	assign go = start && !accLoad;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_word_add_sum: assert property (
		go && opcode == OP_ADD_WORD |=> accumulator ==
		{16'h0000, $past(accumulator[15:0])} + $past(op16))
		else $error("word add sum wrong");
	a_double_add_flags: assert property (
		go && opcode == OP_ADD_DOUBLE |=> accumulator == $past(sum33[31:0])
		&& carry32Flag == $past(sum33[32]) && signErrorFlag ==
		$past(accumulator[31] == op32[31] && sum33[31] != accumulator[31]))
		else $error("double add wrong");
	a_sub_word_borrow: assert property (
		go && opcode == OP_SUB_WORD |=> borrow16Flag ==
		$past(accumulator[15:0] < op16) && accumulator ==
		$past(accumulator - {16'h0000, op16}))
		else $error("word subtract wrong");
	a_zero_negative: assert property (
		go && opcode inside {[OP_ADD_WORD:OP_DIVIDE]} |=>
		zeroResultFlag == (accumulator == 32'h0000_0000)
		&& negativeFlag == accumulator[31])
		else $error("zero or negative flag wrong");
	a_multiply_keeps: assert property (
		go && opcode == OP_MULTIPLY |=> accumulator ==
		{16'h0000, $past(accumulator[15:0])} * $past(op16) && $stable({
		carry16Flag, carry32Flag, borrow16Flag, signErrorFlag,
		invalidBcdFlag})) else $error("multiply wrong");
	a_divide_by_zero: assert property (
		go && opcode == OP_DIVIDE && op16 == 16'h0000 |=> operandSizeFlag
		&& $stable(accumulator) && $stable(stackTop))
		else $error("divide by zero wrong");
	a_divide_result: assert property (
		go && opcode == OP_DIVIDE && op16 != 16'h0000 |=> !operandSizeFlag
		&& accumulator == $past(accumulator) / $past(op16)
		&& stackTop == $past(accumulator) % $past(op16))
		else $error("divide wrong");
	a_step_write: assert property (
		go && opcode inside {OP_INCREMENT, OP_DECREMENT} |=> memWriteEn
		&& $stable(accumulator) && zeroResultFlag == (memWriteData == 0)
		&& memWriteData == ($past(opcode) == OP_INCREMENT ?
		$past(memWord) + 16'h0001 : $past(memWord) - 16'h0001))
		else $error("step write wrong");
endmodule : baau_arith_unit_properties

bind baau_arith_unit baau_arith_unit_properties i_props (.*);

// [verif/baau_mem_model.sv]
/* data memory of the sequencer, sixteen words.
 * assumes the bench preloads words and picks the address. */
`timescale 1ns/1ps
module baau_mem_model (
	input wire logic clk,
	input wire logic [3:0] addr,
	input wire logic memWriteEn,
	input wire logic [15:0] memWriteData,
	output logic [15:0] memWord,
	output logic [15:0] memWordHigh
);
	logic [15:0] mem [16];
	logic [3:0] addrQ;
	assign memWord = mem[addr];
	assign memWordHigh = mem[addr + 4'h1];
	// the write-back lands a cycle late, so the taking address is kept
	always @(posedge clk) begin
		addrQ <= addr;
		if (memWriteEn) begin
			mem[addrQ] <= memWriteData;
		end
	end
endmodule : baau_mem_model

// [verif/tb.sv]
/* self-checking bench for the arithmetic unit.
 * assumes the unit answers one cycle after each start. */
`timescale 1ns/1ps
module tb
	import baau_pkg::*;
;
	logic clk, rstn, start, useConst, accLoad, memWriteEn, done;
	baau_op_type opcode;
	logic [15:0] memWord, memWordHigh, memWriteData, memE;
	logic [31:0] constValue, accLoadValue, accumulator, stackTop, rnd;
	logic [31:0] accE, stkE, bcdE;
	logic bcdBad;
	logic [BIT_SPACE-1:0] discreteBits;
	logic [BIT_ADDR_W-1:0] bitAddr;
	logic [RUN_W-1:0] bitCount;
	logic zeroResultFlag, carry16Flag, carry32Flag, borrow16Flag;
	logic borrow32Flag, negativeFlag, signErrorFlag, operandSizeFlag;
	logic invalidBcdFlag;
	logic [3:0] addr;
	baau_flags_type flE;
	logic [88:0] expQ[$];
	int num_errors, checks_done;
	baau_arith_unit i_baau_arith_unit (.*);
	baau_mem_model i_baau_mem_model (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic compare(input logic [88:0] got, input logic [88:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : compare
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// word operands read the same from memory or constant, so uc is free
	task automatic issue(input baau_op_type op, input logic uc,
		input logic [31:0] v);
		logic [31:0] a, b, r;
		logic [32:0] s;
		logic [16:0] c;
		addr = 4'($urandom);
		i_baau_mem_model.mem[addr] = v[15:0];
		i_baau_mem_model.mem[addr + 4'h1] = v[31:16];
		start = 1'b1;
		opcode = op;
		useConst = uc;
		constValue = v;
		a = (op == OP_ADD_WORD) ? {16'h0000, accE[15:0]} : accE;
		b = (op inside {OP_ADD_DOUBLE, OP_SUB_DOUBLE}) ? v : {16'h0000, v[15:0]};
		r = accE;
		case (op)
		OP_ADD_WORD, OP_ADD_DOUBLE: begin
			s = {1'b0, a} + b;
			c = {1'b0, a[15:0]} + b[15:0];
			r = s[31:0];
			flE.carry16 = c[16];
			flE.carry32 = s[32];
			flE.signError = a[31] == b[31] && r[31] != a[31];
		end
		OP_SUB_WORD: begin
			r = accE - b;
			flE.borrow16 = accE[15:0] < b[15:0];
		end
		OP_SUB_DOUBLE: begin
			r = accE - b;
			flE.borrow32 = accE < b;
		end
		OP_MULTIPLY: r = {16'h0000, accE[15:0]} * b;
		OP_DIVIDE: begin
			flE.operandSize = b == 0;
			if (b != 0) begin
				r = accE / b;
				stkE = accE % b;
			end
		end
		OP_INCREMENT: memE = v[15:0] + 16'h0001;
		OP_DECREMENT: memE = v[15:0] - 16'h0001;
		OP_BCD_ADD: if (bitCount inside {[6'h01:6'h20]}) begin
			// only the bcd-owned flags move, the rest are kept
			r = bcdE;
			flE.carry16 = 1'b0;
			flE.carry32 = 1'b0;
			flE.invalidBcd = bcdBad;
			flE.zero = bcdE == 0;
			flE.negative = bcdE[31];
		end
		default: ;
		endcase
		if (op inside {[OP_ADD_WORD:OP_DIVIDE]}) begin
			flE.zero = r == 0;
			flE.negative = r[31];
		end
		if (op inside {OP_INCREMENT, OP_DECREMENT})
			flE.zero = memE == 0;
		accE = r;
		if (op inside {[OP_ADD_WORD:OP_BCD_ADD]})
			expQ.push_back({accE, stkE, memE, flE});
		@(posedge clk);
		#2;
	endtask : issue
	task automatic load(input logic [31:0] v);
		start = 1'b0;
		accLoad = 1'b1;
		accLoadValue = v;
		accE = v;
		@(posedge clk);
		#2;
		accLoad = 1'b0;
	endtask : load
	always @(negedge clk) begin
		if (done === 1'b1) begin
			compare({accumulator, stackTop, memWriteData, zeroResultFlag,
				carry16Flag, carry32Flag, borrow16Flag, borrow32Flag,
				negativeFlag, signErrorFlag, operandSizeFlag, invalidBcdFlag},
				expQ.size() > 0 ? expQ.pop_front() : 'x);
		end
	end
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{rstn, start, useConst, accLoad, accLoadValue, constValue} = '0;
		{addr, discreteBits, bitCount, accE, stkE, memE, flE} = '0;
		{bcdE, bcdBad} = '0;
		opcode = OP_NONE;
		bitAddr = 11'h064;
		void'($urandom(4333));
		repeat (5) @(posedge clk);
		#2;
		rstn = 1'b1;
		load(32'h0000_ffff);
		issue(OP_ADD_WORD, 1'b0, 32'h0000_0001);
		issue(OP_INCREMENT, 1'b0, 32'h0000_ffff);
		issue(OP_DECREMENT, 1'b0, 32'h0000_0001);
		issue(OP_DIVIDE, 1'b1, 32'h0000_0000);
		issue(OP_SUB_WORD, 1'b1, 32'h0001_0001);
		issue(OP_ADD_DOUBLE, 1'b1, 32'hffff_0001);
		issue(OP_ADD_DOUBLE, 1'b0, 32'h7fff_ffff);
		issue(OP_ADD_DOUBLE, 1'b1, 32'h0000_0001);
		issue(OP_SUB_DOUBLE, 1'b0, 32'h8000_0001);
		for (int i = 0; i < 60; i++) begin
			rnd = $urandom;
			// opposite sign bits keep the word-add sign error unambiguous
			rnd[15] = ~accE[15];
			opcode = baau_op_type'($urandom_range(8, 1));
			issue(opcode, 1'($urandom), rnd);
		end
		load(32'h0000_0019);
		discreteBits[131:100] = 32'h0000_0027;
		bcdE = 32'h0000_0046;
		issue(OP_BCD_ADD, 1'b0, 32'h0000_0000);
		bitCount = 6'h21;
		issue(OP_BCD_ADD, 1'b0, 32'h0000_0000);
		bitCount = 6'h20;
		issue(OP_BCD_ADD, 1'b0, 32'h0000_0000);
		// a four-bit run holding digit a is not a valid bcd digit
		discreteBits[131:100] = 32'h0000_000a;
		bitCount = 6'h04;
		bcdE = 32'h0000_0056;
		bcdBad = 1'b1;
		issue(OP_BCD_ADD, 1'b0, 32'h0000_0000);
		issue(OP_NONE, 1'b0, 32'h0000_0000);
		issue(baau_op_type'(4'hf), 1'b0, 32'h0000_0000);
		start = 1'b0;
		repeat (3) @(posedge clk);
		compare(89'(expQ.size()), 89'h0);
		tally_and_finish();
	end
endmodule : tb
